// ==== design/host_command_mailbox.v ====
`timescale 1ns/1ns
`default_nettype none
`include "host_command_mailbox_map.vh"

module host_command_mailbox
(
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Host side of the scratch word
	input wire host_wr_en,
	input wire [31:0] host_wr_data,
	output reg [31:0] command_response_word,
	// Local bus access
	output reg mem_req,
	output reg mem_we,
	output reg [1:0] mem_size,
	output reg [31:0] mem_addr,
	output reg [31:0] mem_wdata,
	input wire mem_ack,
	input wire [31:0] mem_rdata,
	// Transfer of control
	output reg exec_start,
	output reg [31:0] exec_addr,
	output reg [31:0] exec_arg
);

	localparam [6:0] ST_INIT = 7'h01;
	localparam [6:0] ST_IDLE = 7'h02;
	localparam [6:0] ST_EXEC = 7'h04;
	localparam [6:0] ST_MEM = 7'h08;
	localparam [6:0] ST_FIN = 7'h10;
	localparam [6:0] ST_DONE = 7'h20;
	localparam [6:0] ST_HALT = 7'h40;

	reg [6:0] state_reg;
	reg [6:0] opcode_reg;
	reg [6:0] options_reg;
	reg [15:0] result_reg;
	reg err_reg;
	reg [31:0] count_reg;
	reg vwr_en;
	reg [1:0] vwr_sel;
	reg [1:0] vwr_half;
	reg [31:0] vwr_data;
	reg [31:0] read_ext;
	reg [31:0] step;
	wire [31:0] virtual_reg_a;
	wire [31:0] virtual_reg_b;
	wire [31:0] virtual_reg_c;
	wire [31:0] virtual_reg_d;
	wire [31:0] vreg_sel;
	wire [1:0] size_code;

	virtual_reg_file u_vregs
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(vwr_en),
		.wr_sel(vwr_sel),
		.wr_half_en(vwr_half),
		.wr_data(vwr_data),
		.virtual_reg_a(virtual_reg_a),
		.virtual_reg_b(virtual_reg_b),
		.virtual_reg_c(virtual_reg_c),
		.virtual_reg_d(virtual_reg_d)
	);

	assign size_code = options_reg[`OPT_SIZE_HI:`OPT_SIZE_LO];
	assign vreg_sel = (options_reg[`OPT_VSEL_HI:`OPT_VSEL_LO] == 2'h0) ? virtual_reg_a :
		(options_reg[`OPT_VSEL_HI:`OPT_VSEL_LO] == 2'h1) ? virtual_reg_b :
		(options_reg[`OPT_VSEL_HI:`OPT_VSEL_LO] == 2'h2) ? virtual_reg_c : virtual_reg_d;

	// Zero-extended read data and address step for the current access size
	always @*
	begin
		case (mem_size)
			`SIZE_8:
			begin
				read_ext = {24'h000000, mem_rdata[7:0]};
				step = 32'h00000001;
			end
			`SIZE_16:
			begin
				read_ext = {16'h0000, mem_rdata[15:0]};
				step = 32'h00000002;
			end
			default:
			begin
				read_ext = mem_rdata;
				step = 32'h00000004;
			end
		endcase
	end

	// Virtual register write port, one write per cycle
	always @*
	begin
		vwr_en = 1'b0;
		vwr_sel = `VSEL_A;
		vwr_half = 2'h3;
		vwr_data = 32'h00000000;
		case (state_reg)
			ST_EXEC:
			begin
				if (opcode_reg == `OPC_VREG && options_reg[`OPT_RW])
				begin
					vwr_en = 1'b1;
					vwr_sel = options_reg[`OPT_VSEL_HI:`OPT_VSEL_LO];
					vwr_half = options_reg[`OPT_HALF] ? 2'h2 : 2'h1;
					vwr_data = {result_reg, result_reg};
				end
				else if (opcode_reg == `OPC_MEM_SIZE)
				begin
					vwr_en = 1'b1;
					vwr_sel = `VSEL_B;
					case ({options_reg[`OPT_RW], options_reg[`OPT_HALF]})
						2'h0: vwr_data = `RAM_ACTUAL_BEGIN;
						2'h1: vwr_data = `RAM_ACTUAL_END;
						2'h2: vwr_data = `RAM_AVAIL_BEGIN;
						default: vwr_data = `RAM_AVAIL_END;
					endcase
				end
			end
			ST_MEM:
			begin
				// Memory reads land zero-extended in the second register
				if (opcode_reg == `OPC_MEM_RW && mem_ack && !mem_we)
				begin
					vwr_en = 1'b1;
					vwr_sel = `VSEL_B;
					vwr_data = read_ext;
				end
			end
			ST_FIN:
			begin
				// Auto-increment runs a cycle later to avoid a port clash with the read
				if (options_reg[`OPT_HALF])
				begin
					vwr_en = 1'b1;
					vwr_sel = `VSEL_A;
					vwr_data = virtual_reg_a + step;
				end
			end
			default:
			begin
				vwr_en = 1'b0;
			end
		endcase
	end

	// Command sequencer
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			command_response_word <= `MBX_CLEAR_VALUE;
			state_reg <= ST_INIT;
			opcode_reg <= 7'h00;
			options_reg <= 7'h00;
			result_reg <= 16'h0000;
			err_reg <= 1'b0;
			count_reg <= 32'h00000000;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_size <= `SIZE_8;
			mem_addr <= 32'h00000000;
			mem_wdata <= 32'h00000000;
			exec_start <= 1'b0;
			exec_addr <= 32'h00000000;
			exec_arg <= 32'h00000000;
		end
		else
		begin
			exec_start <= 1'b0;
			case (state_reg)
				ST_INIT:
				begin
					command_response_word <= `MBX_READY_PATTERN;
					state_reg <= ST_IDLE;
				end
				ST_IDLE:
				begin
					// host writes accepted only while it owns the word
					if (host_wr_en && command_response_word[`MBX_OWN_BIT])
						command_response_word <= host_wr_data;
					// a cleared flag marks a pending command
					else if (!command_response_word[`MBX_OWN_BIT])
					begin
						opcode_reg <= command_response_word[`MBX_OPC_HI:`MBX_OPC_LO];
						options_reg <= command_response_word[`MBX_OPT_HI:`MBX_OPT_LO];
						result_reg <= command_response_word[`MBX_DATA_HI:`MBX_DATA_LO];
						err_reg <= 1'b0;
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					state_reg <= ST_DONE;
					case (opcode_reg)
						`OPC_VREG:
						begin
							// lower half is word bits 16 to 31
							if (!options_reg[`OPT_RW])
								result_reg <= options_reg[`OPT_HALF] ? vreg_sel[31:16] :
									vreg_sel[15:0];
						end
						`OPC_MEM_INIT:
						begin
							mem_we <= 1'b1;
							mem_size <= `SIZE_8;
							mem_addr <= virtual_reg_a;
							mem_wdata <= {24'h000000, result_reg[7:0]};
							count_reg <= virtual_reg_b;
							if (virtual_reg_b != 32'h00000000)
							begin
								mem_req <= 1'b1;
								state_reg <= ST_MEM;
							end
						end
						`OPC_MEM_RW:
						begin
							if (size_code == 2'h3)
							begin
								err_reg <= 1'b1;
								result_reg <= `ERR_BAD_SIZE;
							end
							else
							begin
								// any local address may be reached
								mem_req <= 1'b1;
								mem_we <= options_reg[`OPT_RW];
								mem_size <= size_code;
								mem_addr <= virtual_reg_a;
								mem_wdata <= (size_code == `SIZE_32) ?
									{virtual_reg_b[31:16], result_reg} : {16'h0000, result_reg};
								state_reg <= ST_MEM;
							end
						end
						`OPC_MEM_SIZE:
						begin
							result_reg <= result_reg;
						end
						`OPC_FW_QUERY:
						begin
							result_reg <= {`FW_MAJOR, `FW_MINOR};
						end
						`OPC_EXEC:
						begin
							// Control leaves for good, so ownership stays clear
							exec_start <= 1'b1;
							exec_addr <= virtual_reg_a;
							exec_arg <= virtual_reg_c;
							state_reg <= ST_HALT;
						end
						default:
						begin
							err_reg <= 1'b1;
							result_reg <= `ERR_BAD_OPCODE;
						end
					endcase
				end
				ST_MEM:
				begin
					if (mem_ack)
					begin
						if (opcode_reg == `OPC_MEM_INIT)
						begin
							count_reg <= count_reg - 32'h00000001;
							mem_addr <= mem_addr + 32'h00000001;
							if (count_reg == 32'h00000001)
							begin
								mem_req <= 1'b0;
								state_reg <= ST_DONE;
							end
						end
						else
						begin
							mem_req <= 1'b0;
							if (!mem_we)
								result_reg <= read_ext[15:0];
							state_reg <= ST_FIN;
						end
					end
				end
				ST_FIN:
				begin
					state_reg <= ST_DONE;
				end
				ST_DONE:
				begin
					// result written together with ownership return
					// error flag 0 pass, 1 fail
					command_response_word <= {1'b1, opcode_reg, err_reg, options_reg, result_reg};
					state_reg <= ST_IDLE;
				end
				ST_HALT:
				begin
					state_reg <= ST_HALT;
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // host_command_mailbox

`default_nettype wire

// ==== design/host_command_mailbox_map.vh ====
`ifndef HOST_COMMAND_MAILBOX_MAP_VH
`define HOST_COMMAND_MAILBOX_MAP_VH

// Word bit n in big-endian numbering is vector bit 31-n
`define MBX_OWN_BIT 31
`define MBX_OPC_HI 30
`define MBX_OPC_LO 24
`define MBX_ERR_BIT 23
`define MBX_OPT_HI 22
`define MBX_OPT_LO 16
`define MBX_DATA_HI 15
`define MBX_DATA_LO 0

// Option field positions (option vector bit 0 is word bit 15)
`define OPT_RW 0
`define OPT_HALF 1
`define OPT_SIZE_LO 2
`define OPT_SIZE_HI 3
`define OPT_VSEL_LO 3
`define OPT_VSEL_HI 4

// Reset values
`define MBX_CLEAR_VALUE 32'h00000000
`define MBX_READY_PATTERN 32'h80525354

// Opcodes
`define OPC_VREG 7'h01
`define OPC_MEM_INIT 7'h02
`define OPC_MEM_RW 7'h03
`define OPC_CHECKSUM 7'h04
`define OPC_MEM_SIZE 7'h05
`define OPC_FW_QUERY 7'h06
`define OPC_EXEC 7'h07

// Error codes
`define ERR_BAD_SIZE 16'h0001
`define ERR_BAD_OPCODE 16'h0002

// Access sizes
`define SIZE_8 2'h0
`define SIZE_16 2'h1
`define SIZE_32 2'h2

// Virtual register selects
`define VSEL_A 2'h0
`define VSEL_B 2'h1

// Memory size query answers and firmware revision (arbitrary defaults)
`define RAM_ACTUAL_BEGIN 32'h00000000
`define RAM_ACTUAL_END 32'h01FFFFFF
`define RAM_AVAIL_BEGIN 32'h00100000
`define RAM_AVAIL_END 32'h01EFFFFF
`define FW_MAJOR 8'h01
`define FW_MINOR 8'h00

`endif

// ==== design/virtual_reg_file.v ====
`timescale 1ns/1ns
`default_nettype none

module virtual_reg_file
(
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Write port
	input wire wr_en,
	input wire [1:0] wr_sel,
	input wire [1:0] wr_half_en,
	input wire [31:0] wr_data,
	// Contents
	output wire [31:0] virtual_reg_a,
	output wire [31:0] virtual_reg_b,
	output wire [31:0] virtual_reg_c,
	output wire [31:0] virtual_reg_d
);

	reg [31:0] vreg [0:3];
	genvar i;

	// One storage word per virtual register, halves written separately
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_vreg
			always @(posedge clk)
			begin
				if (sys_rst)
					vreg[i] <= 32'h00000000;
				else if (wr_en && (wr_sel == i))
				begin
					if (wr_half_en[1])
						vreg[i][31:16] <= wr_data[31:16];
					if (wr_half_en[0])
						vreg[i][15:0] <= wr_data[15:0];
				end
			end
		end
	endgenerate

	assign virtual_reg_a = vreg[0];
	assign virtual_reg_b = vreg[1];
	assign virtual_reg_c = vreg[2];
	assign virtual_reg_d = vreg[3];

endmodule // virtual_reg_file

`default_nettype wire

// ==== verif/host_command_mailbox_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module mailbox_checker
(
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Watched ports
	input wire host_wr_en,
	input wire [31:0] host_wr_data,
	input wire [31:0] command_response_word,
	input wire mem_req,
	input wire mem_ack,
	input wire [31:0] mem_addr,
	input wire exec_start
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Short aliases for the word
	wire [31:0] w = command_response_word;
	wire own = w[31];
	// Command taken while the host owns the word
	sequence cmd_taken;
		own && host_wr_en && !host_wr_data[31] && host_wr_data[30:24] != 7'h07;
	endsequence
	// Word handed back within a bounded time
	sequence cmd_done;
		!own ##[1:60] own;
	endsequence
	rdy_after_rst_a: assert property ($fell(sys_rst) |=> w == 32'h80525354)
		else $error("ready pattern missing");
	clr_in_rst_a: assert property (disable iff (1'b0) sys_rst ##1 sys_rst |-> w == 32'h0)
		else $error("word not cleared in reset");
	write_take_a: assert property (own && host_wr_en |=> w == $past(host_wr_data))
		else $error("host write lost");
	pend_stable_a: assert property (!own ##1 !own |-> $stable(w))
		else $error("word changed while pending");
	own_return_a: assert property (cmd_taken |=> cmd_done)
		else $error("ownership not returned");
	err_code_a: assert property ($rose(own) && w[23] |-> w[15:0] inside {16'h1, 16'h2})
		else $error("bad error code");
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("bus request dropped");
	exec_only_a: assert property (exec_start |-> !own && w[30:24] == 7'h07)
		else $error("stray execute");
endmodule // mailbox_checker
bind host_command_mailbox mailbox_checker chk (.clk(clk), .sys_rst(sys_rst),
	.host_wr_en(host_wr_en), .host_wr_data(host_wr_data),
	.command_response_word(command_response_word), .mem_req(mem_req),
	.mem_ack(mem_ack), .mem_addr(mem_addr), .exec_start(exec_start));
`default_nettype wire

// ==== verif/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module host_model
(
	// Clock
	input wire clk,
	// Scratch word
	input wire [31:0] command_response_word,
	output logic host_wr_en,
	output logic [31:0] host_wr_data
);
	initial
	begin
		host_wr_en = 1'b0;
		host_wr_data = 32'h0;
	end
	// One write pulse; data scrambled afterwards
	task automatic poke(input logic [31:0] v);
		host_wr_en = 1'b1;
		host_wr_data = v;
		@(posedge clk);
		#1;
		host_wr_en = 1'b0;
		host_wr_data = ~v;
	endtask
	// Bounded wait for ownership
	task automatic wait_own();
		repeat (200)
		begin
			@(posedge clk);
			#1;
			if (command_response_word[31] === 1'b1)
				break;
		end
	endtask
	task automatic issue(input logic [31:0] cmd, output logic [31:0] resp);
		wait_own();
		poke({1'b0, cmd[30:0]});
		wait_own();
		resp = command_response_word;
	endtask
endmodule // host_model
`default_nettype wire

// ==== verif/host_command_mailbox_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "host_command_mailbox_map.vh"
module host_command_mailbox_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mem_ack = 1'b0;
	logic [31:0] mem_rdata = 32'hA5A5A5A5;
	wire host_wr_en, mem_req, mem_we, exec_start;
	wire [1:0] mem_size;
	wire [31:0] host_wr_data, command_response_word, mem_addr, mem_wdata, exec_addr, exec_arg;
	logic [31:0] vr [4];
	logic [31:0] em [logic [31:0]];
	logic [31:0] pm [logic [31:0]];
	logic [31:0] seed = 32'h00016B12;
	int err_total = 0;
	int n_tests = 0;
	int dly = 0;
	int cnt = 0;
	host_command_mailbox dut (.clk, .sys_rst, .host_wr_en, .host_wr_data,
		.command_response_word, .mem_req, .mem_we, .mem_size, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata, .exec_start, .exec_addr, .exec_arg);
	host_model host (.clk, .command_response_word, .host_wr_en, .host_wr_data);
	initial
	begin
		forever #5 clk = ~clk;
	end
	// Local memory: answers after dly cycles, masked to access size
	always @(posedge clk)
	begin
		#1;
		mem_rdata = ~mem_rdata;
		if (mem_ack || !mem_req)
			{mem_ack, cnt} = 0;
		else if (cnt < dly)
			cnt++;
		else
		begin
			mem_ack = 1'b1;
			if (mem_we)
				pm[mem_addr] = mem_wdata & (mem_size == 0 ? 32'hFF : mem_size == 1 ? 32'hFFFF : '1);
			mem_rdata = pm.exists(mem_addr) ? pm[mem_addr] : 32'h0;
		end
	end
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", s, exp, seen);
		end
	endtask
	// Issue one command and compare with the model
	task automatic run(input logic [6:0] op, input logic [6:0] opt, input logic [15:0] d);
		logic [31:0] r;
		logic [31:0] m;
		logic [15:0] res;
		logic e;
		int sz;
		{res, e, m, sz} = {d, 1'b0, 32'hFFFFFFFF, 30'h0, opt[3:2]};
		case (op)
		7'h01:
			if (!opt[0])
				res = opt[1] ? vr[opt[4:3]][31:16] : vr[opt[4:3]][15:0];
			else if (opt[1])
				vr[opt[4:3]][31:16] = d;
			else
				vr[opt[4:3]][15:0] = d;
		7'h02:
		begin
			m = 32'hFFFF0000;
			for (int i = 0; i < vr[1]; i++)
				em[vr[0] + i] = {24'h0, d[7:0]};
		end
		7'h03:
		begin
			if (sz == 3)
				{e, res} = {1'b1, 16'h0001};
			else if (opt[0])
			begin
				m = 32'hFFFF0000;
				em[vr[0]] = {vr[1][31:16], d} & (sz == 0 ? 32'hFF : sz == 1 ? 32'hFFFF : '1);
			end
			else
			begin
				vr[1] = em[vr[0]];
				res = vr[1][15:0];
			end
			if (opt[1] && sz != 3)
				vr[0] = vr[0] + (1 << sz);
		end
		7'h05:
			vr[1] = opt[0] ? (opt[1] ? `RAM_AVAIL_END : `RAM_AVAIL_BEGIN)
				: (opt[1] ? `RAM_ACTUAL_END : `RAM_ACTUAL_BEGIN);
		7'h06:
			res = {`FW_MAJOR, `FW_MINOR};
		default:
			{e, res} = {1'b1, 16'h0002};
		endcase
		host.issue({1'b0, op, 1'b0, opt, d}, r);
		check("word", r & m, {1'b1, op, e, opt, res} & m);
	endtask
	task automatic setvr(input logic [1:0] s, input logic [31:0] v);
		run(7'h01, {2'b00, s, 3'b011}, v[31:16]);
		run(7'h01, {2'b00, s, 3'b001}, v[15:0]);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence; a slow bus and a refused write are mixed in
	initial
	begin
		repeat (8) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		@(posedge clk);
		#1;
		check("ready", command_response_word, 32'h80525354);
		for (int i = 0; i < 8; i++)
		begin
			run(7'h01, {2'b00, i[2:1], 1'b0, i[0], 1'b1}, rnd());
			run(7'h01, {2'b00, i[2:1], 1'b0, i[0], 1'b0}, 16'h0);
		end
		$display("test vreg done");
		setvr(0, 32'h1000);
		setvr(1, {rnd(), 16'h0});
		for (int s = 0; s < 3; s++)
			run(7'h03, {3'b000, s[1:0], 2'b11}, rnd());
		run(7'h03, 7'h0D, 16'h0);
		setvr(0, 32'h1000);
		dly = 3;
		for (int s = 0; s < 3; s++)
			fork
				run(7'h03, {3'b000, s[1:0], 2'b10}, 16'h0);
				begin
					repeat (3) @(posedge clk);
					#1;
					host.poke(32'h7F7F7F7F);
				end
			join
		$display("test memory done");
		setvr(0, 32'h2000);
		setvr(1, 32'h3);
		run(7'h02, 7'h00, rnd());
		setvr(0, 32'h2000);
		for (int k = 0; k < 3; k++)
			run(7'h03, 7'h02, 16'h0);
		// Without auto-increment the address stays put, so the read hits the same byte
		run(7'h03, 7'h01, rnd());
		run(7'h03, 7'h00, 16'h0);
		// A zero count fill must finish at once and leave that byte alone
		setvr(1, 32'h0);
		run(7'h02, 7'h00, rnd());
		run(7'h03, 7'h00, 16'h0);
		for (int q = 0; q < 4; q++)
		begin
			run(7'h05, {5'b00000, q[1:0]}, rnd());
			run(7'h01, 7'h08, 16'h0);
			run(7'h01, 7'h0A, 16'h0);
		end
		run(7'h06, 7'h00, 16'h0);
		run(7'h04, 7'h00, 16'h0);
		run(7'h7F, 7'h00, 16'h0);
		$display("test query done");
		setvr(0, {rnd(), rnd()});
		setvr(2, {rnd(), rnd()});
		host.poke(32'h07000000);
		repeat (20)
		begin
			@(posedge clk);
			#1;
			if (exec_start === 1'b1)
				break;
		end
		check("exec_start", {31'h0, exec_start}, 32'h1);
		check("exec_addr", exec_addr, vr[0]);
		check("exec_arg", exec_arg, vr[2]);
		check("halted", command_response_word, 32'h07000000);
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check("clear", command_response_word, 32'h0);
		sys_rst = 1'b0;
		@(posedge clk);
		#1;
		check("ready", command_response_word, 32'h80525354);
		$display("test exec done");
		give_verdict();
	end
	// Watchdog; the tests need about 400 cycles
	initial
	begin
		#200000;
		err_total++;
		give_verdict();
	end
endmodule // host_command_mailbox_tb
`default_nettype wire
